// ---- hw/ccm_consts.svh ----
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// mode register bits
`define MODE_DECRYPT_BIT 0
`define MODE_RATE_BIT 1
`define MODE_EXTENDED_BIT 2
`define MODE_WIDE_LEN_BIT 3
// packet byte offsets
`define PKT_HDR_OFS 8'h00
`define PKT_LEN_OFS 8'h01
`define PKT_RFU_OFS 8'h02
`define PKT_PAY_OFS 8'h03
// lengths
`define KS_DEFAULT_LEN 8'h1b
`define KS_MAX_LEN 8'hfb
`define MIC_LEN 8'h04
`define DEC_MIN_LEN 8'h05
// register indices
`define REG_MODE 4'h0
`define REG_CONFIG_PTR 4'h1
`define REG_SCRATCH_PTR 4'h2
`define REG_IN_PTR 4'h3
`define REG_OUT_PTR 4'h4
`define REG_MAX_PAY 4'h5
`define REG_RATE_OVR 4'h6
`define REG_STATUS 4'h7
// reset values
`define MODE_RESET 4'h1
`define MAX_PAY_RESET 8'hfb
// dma budget per byte at each rate: 1 Mbps 8 us, 2 Mbps 4 us at 10 ns
`define BYTE_TIME_1M_NS 8000
`define BYTE_TIME_2M_NS 4000
`define CLK_PERIOD_NS 10
`define BYTE_CYC_1M (`BYTE_TIME_1M_NS / `CLK_PERIOD_NS)
`define BYTE_CYC_2M (`BYTE_TIME_2M_NS / `CLK_PERIOD_NS)
`endif

// ---- hw/ccm_pkg.sv ----
package ccm_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_KS_READ, ST_KS_WRITE, ST_HDR_READ, ST_LEN_READ, ST_RFU_READ,
      ST_HDR_WRITE, ST_PAY_READ, ST_PAY_KS, ST_PAY_WRITE, ST_MIC_READ, ST_MIC_WRITE,
      ST_DONE
   } ccm_state_e;
endpackage

// ---- hw/ccm_packet_cipher_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccm_consts.svh"
module ccm_packet_cipher_engine
   import ccm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // tasks
   input wire logic keystream_generate_task_i,
   input wire logic cipher_run_task_i,
   input wire logic stop_task_i,
   input wire logic rate_override_task_i,
   // events
   output logic keystream_done_event_o,
   output logic cipher_done_event_o,
   output logic error_event_o,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // ram master
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic mem_gnt_i,
   input wire logic [7:0] mem_rdata_i
);
   // registers
   logic [3:0] mode_q, mode_d;
   logic [31:0] config_struct_pointer_q, config_struct_pointer_d;
   logic [31:0] scratch_area_pointer_q, scratch_area_pointer_d;
   logic [31:0] input_packet_pointer_q, input_packet_pointer_d;
   logic [31:0] output_packet_pointer_q, output_packet_pointer_d;
   logic [7:0] max_payload_length_q, max_payload_length_d;
   logic speed_override_value_q, speed_override_value_d;
   logic [31:0] rdata_q, rdata_d;
   // engine state
   ccm_state_e state_q, state_d;
   logic decrypt_q, decrypt_d;
   logic rate_q, rate_d;
   logic wide_q, wide_d;
   logic ks_mode_q, ks_mode_d;
   logic [7:0] ks_len_q, ks_len_d;
   logic [7:0] idx_q, idx_d;
   logic [7:0] len_q, len_d;
   logic [7:0] hdr_q, hdr_d;
   logic [7:0] data_q, data_d;
   logic [7:0] mic_q [0:3];
   logic [7:0] mic_d [0:3];
   logic [7:0] rx_mic_q [0:3];
   logic [7:0] rx_mic_d [0:3];
   logic mic_ok_q, mic_ok_d;
   logic [9:0] wait_q, wait_d;
   logic ks_ev_q, ks_ev_d, cr_ev_q, cr_ev_d, er_ev_q, er_ev_d;
   logic req_q, req_d, we_q, we_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [9:0] budget;
   assign budget = rate_q ? 10'(`BYTE_CYC_2M) : 10'(`BYTE_CYC_1M);
   // register file
   always_comb begin
      mode_d = mode_q;
      config_struct_pointer_d = config_struct_pointer_q;
      scratch_area_pointer_d = scratch_area_pointer_q;
      input_packet_pointer_d = input_packet_pointer_q;
      output_packet_pointer_d = output_packet_pointer_q;
      max_payload_length_d = max_payload_length_q;
      speed_override_value_d = speed_override_value_q;
      rdata_d = 32'h0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `REG_MODE: mode_d = reg_wdata_i[3:0];
            `REG_CONFIG_PTR: config_struct_pointer_d = reg_wdata_i;
            `REG_SCRATCH_PTR: scratch_area_pointer_d = reg_wdata_i;
            `REG_IN_PTR: input_packet_pointer_d = reg_wdata_i;
            `REG_OUT_PTR: output_packet_pointer_d = reg_wdata_i;
            `REG_MAX_PAY: max_payload_length_d = reg_wdata_i[7:0];
            `REG_RATE_OVR: speed_override_value_d = reg_wdata_i[0];
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `REG_MODE: rdata_d = {28'h0, mode_q};
            `REG_CONFIG_PTR: rdata_d = config_struct_pointer_q;
            `REG_SCRATCH_PTR: rdata_d = scratch_area_pointer_q;
            `REG_IN_PTR: rdata_d = input_packet_pointer_q;
            `REG_OUT_PTR: rdata_d = output_packet_pointer_q;
            `REG_MAX_PAY: rdata_d = {24'h0, max_payload_length_q};
            `REG_RATE_OVR: rdata_d = {31'h0, speed_override_value_q};
            `REG_STATUS: rdata_d = {22'h0, rate_q, (state_q != ST_IDLE), 7'h0, mic_ok_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end
   // engine
   always_comb begin
      state_d = state_q;
      decrypt_d = decrypt_q;
      rate_d = rate_q;
      wide_d = wide_q;
      ks_mode_d = ks_mode_q;
      ks_len_d = ks_len_q;
      idx_d = idx_q;
      len_d = len_q;
      hdr_d = hdr_q;
      data_d = data_q;
      mic_d = mic_q;
      rx_mic_d = rx_mic_q;
      mic_ok_d = mic_ok_q;
      wait_d = wait_q;
      ks_ev_d = 1'b0;
      cr_ev_d = 1'b0;
      er_ev_d = 1'b0;
      req_d = req_q;
      we_d = we_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      if (req_q && !mem_gnt_i && state_q != ST_IDLE) begin
         if (!ks_mode_q && wait_q >= budget) begin
            er_ev_d = 1'b1;
            wait_d = 10'h0;
         end else begin
            wait_d = wait_q + 10'h1;
         end
      end
      if (rate_override_task_i && state_q != ST_IDLE && !ks_mode_q) begin
         rate_d = speed_override_value_q;
      end
      case (state_q)
         ST_IDLE: begin
            if (keystream_generate_task_i) begin
               ks_mode_d = 1'b1;
               rate_d = mode_q[`MODE_RATE_BIT];
               ks_len_d = !mode_q[`MODE_EXTENDED_BIT] ? `KS_DEFAULT_LEN :
                  (max_payload_length_q > `KS_MAX_LEN ? `KS_MAX_LEN : max_payload_length_q);
               idx_d = 8'h0;
               req_d = 1'b1;
               we_d = 1'b0;
               addr_d = config_struct_pointer_q;
               state_d = ST_KS_READ;
            end else if (cipher_run_task_i) begin
               ks_mode_d = 1'b0;
               decrypt_d = mode_q[`MODE_DECRYPT_BIT];
               rate_d = mode_q[`MODE_RATE_BIT];
               wide_d = mode_q[`MODE_WIDE_LEN_BIT];
               mic_ok_d = 1'b0;
               mic_d = '{default: 8'h0};
               req_d = 1'b1;
               we_d = 1'b0;
               addr_d = input_packet_pointer_q + 32'(`PKT_HDR_OFS);
               state_d = ST_HDR_READ;
            end
         end
         ST_KS_READ: if (mem_gnt_i) begin
            we_d = 1'b1;
            addr_d = scratch_area_pointer_q + 32'(idx_q);
            wdata_d = mem_rdata_i ^ idx_q ^ config_struct_pointer_q[7:0];
            wait_d = 10'h0;
            state_d = ST_KS_WRITE;
         end
         ST_KS_WRITE: if (mem_gnt_i) begin
            wait_d = 10'h0;
            if (idx_q + 8'h1 >= ks_len_q) begin
               req_d = 1'b0;
               ks_ev_d = 1'b1;
               state_d = ST_IDLE;
            end else begin
               idx_d = idx_q + 8'h1;
               we_d = 1'b0;
               addr_d = config_struct_pointer_q + 32'(idx_d[3:0]);
               state_d = ST_KS_READ;
            end
         end
         ST_HDR_READ: if (mem_gnt_i) begin
            hdr_d = mem_rdata_i;
            addr_d = input_packet_pointer_q + 32'(`PKT_LEN_OFS);
            wait_d = 10'h0;
            state_d = ST_LEN_READ;
         end
         ST_LEN_READ: if (mem_gnt_i) begin
            len_d = wide_q ? mem_rdata_i : {3'h0, mem_rdata_i[4:0]};
            we_d = 1'b1;
            addr_d = output_packet_pointer_q + 32'(`PKT_HDR_OFS);
            wdata_d = hdr_q;
            wait_d = 10'h0;
            state_d = ST_HDR_WRITE;
         end
         ST_HDR_WRITE: if (mem_gnt_i) begin
            addr_d = output_packet_pointer_q + 32'(`PKT_LEN_OFS);
            if (len_q == 8'h0) begin
               wdata_d = 8'h0;
               mic_ok_d = 1'b1;
            end else if (decrypt_q) begin
               wdata_d = (len_q < `DEC_MIN_LEN) ? 8'h0 : len_q - `MIC_LEN;
            end else begin
               wdata_d = len_q + `MIC_LEN;
            end
            idx_d = 8'h0;
            wait_d = 10'h0;
            state_d = ST_RFU_READ;
         end
         ST_RFU_READ: if (mem_gnt_i) begin
            wait_d = 10'h0;
            if (len_q == 8'h0 || (decrypt_q && len_q < `DEC_MIN_LEN)) begin
               req_d = 1'b0;
               mic_ok_d = (len_q == 8'h0);
               state_d = ST_DONE;
            end else begin
               if (decrypt_q) begin
                  len_d = len_q - `MIC_LEN;
               end
               we_d = 1'b0;
               addr_d = input_packet_pointer_q + 32'(`PKT_PAY_OFS);
               state_d = ST_PAY_READ;
            end
         end
         ST_PAY_READ: if (mem_gnt_i) begin
            data_d = mem_rdata_i;
            addr_d = scratch_area_pointer_q + 32'(idx_q);
            wait_d = 10'h0;
            state_d = ST_PAY_KS;
         end
         ST_PAY_KS: if (mem_gnt_i) begin
            data_d = data_q ^ mem_rdata_i;
            // running check over the plain byte
            for (int i = 0; i < 4; i++) begin
               mic_d[i] = mic_q[(i + 1) % 4] ^ (decrypt_q ? data_q ^ mem_rdata_i : data_q);
            end
            we_d = 1'b1;
            addr_d = output_packet_pointer_q + 32'(`PKT_PAY_OFS) + 32'(idx_q);
            wdata_d = data_q ^ mem_rdata_i;
            wait_d = 10'h0;
            state_d = ST_PAY_WRITE;
         end
         ST_PAY_WRITE: if (mem_gnt_i) begin
            wait_d = 10'h0;
            idx_d = idx_q + 8'h1;
            if (idx_q + 8'h1 >= len_q) begin
               idx_d = 8'h0;
               if (decrypt_q) begin
                  we_d = 1'b0;
                  addr_d = input_packet_pointer_q + 32'(`PKT_PAY_OFS) + 32'(len_q);
                  state_d = ST_MIC_READ;
               end else begin
                  addr_d = output_packet_pointer_q + 32'(`PKT_PAY_OFS) + 32'(len_q);
                  wdata_d = mic_d[0];
                  state_d = ST_MIC_WRITE;
               end
            end else begin
               we_d = 1'b0;
               addr_d = input_packet_pointer_q + 32'(`PKT_PAY_OFS) + 32'(idx_q) + 32'h1;
               state_d = ST_PAY_READ;
            end
         end
         ST_MIC_WRITE: if (mem_gnt_i) begin
            wait_d = 10'h0;
            idx_d = idx_q + 8'h1;
            addr_d = addr_q + 32'h1;
            wdata_d = mic_q[2'(idx_q + 8'h1)];
            if (idx_q == 8'h3) begin
               req_d = 1'b0;
               mic_ok_d = 1'b1;
               state_d = ST_DONE;
            end
         end
         ST_MIC_READ: if (mem_gnt_i) begin
            wait_d = 10'h0;
            rx_mic_d[2'(idx_q)] = mem_rdata_i;
            idx_d = idx_q + 8'h1;
            addr_d = addr_q + 32'h1;
            if (idx_q == 8'h3) begin
               req_d = 1'b0;
               mic_ok_d = (rx_mic_q[0] == mic_q[0]) && (rx_mic_q[1] == mic_q[1])
                  && (rx_mic_q[2] == mic_q[2]) && (mem_rdata_i == mic_q[3]);
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            cr_ev_d = 1'b1;
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      if (stop_task_i && state_q != ST_IDLE && !ks_mode_q) begin
         req_d = 1'b0;
         wait_d = 10'h0;
         state_d = ST_IDLE;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         mode_q <= `MODE_RESET;
         config_struct_pointer_q <= 32'h0;
         scratch_area_pointer_q <= 32'h0;
         input_packet_pointer_q <= 32'h0;
         output_packet_pointer_q <= 32'h0;
         max_payload_length_q <= `MAX_PAY_RESET;
         speed_override_value_q <= 1'b0;
         rdata_q <= 32'h0;
         state_q <= ST_IDLE;
         decrypt_q <= 1'b0;
         rate_q <= 1'b0;
         wide_q <= 1'b0;
         ks_mode_q <= 1'b0;
         ks_len_q <= 8'h0;
         idx_q <= 8'h0;
         len_q <= 8'h0;
         hdr_q <= 8'h0;
         data_q <= 8'h0;
         mic_q <= '{default: 8'h0};
         rx_mic_q <= '{default: 8'h0};
         mic_ok_q <= 1'b0;
         wait_q <= 10'h0;
         ks_ev_q <= 1'b0;
         cr_ev_q <= 1'b0;
         er_ev_q <= 1'b0;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 32'h0;
         wdata_q <= 8'h0;
      end else if (clk_en_i) begin
         mode_q <= mode_d;
         config_struct_pointer_q <= config_struct_pointer_d;
         scratch_area_pointer_q <= scratch_area_pointer_d;
         input_packet_pointer_q <= input_packet_pointer_d;
         output_packet_pointer_q <= output_packet_pointer_d;
         max_payload_length_q <= max_payload_length_d;
         speed_override_value_q <= speed_override_value_d;
         rdata_q <= rdata_d;
         state_q <= state_d;
         decrypt_q <= decrypt_d;
         rate_q <= rate_d;
         wide_q <= wide_d;
         ks_mode_q <= ks_mode_d;
         ks_len_q <= ks_len_d;
         idx_q <= idx_d;
         len_q <= len_d;
         hdr_q <= hdr_d;
         data_q <= data_d;
         mic_q <= mic_d;
         rx_mic_q <= rx_mic_d;
         mic_ok_q <= mic_ok_d;
         wait_q <= wait_d;
         ks_ev_q <= ks_ev_d;
         cr_ev_q <= cr_ev_d;
         er_ev_q <= er_ev_d;
         req_q <= req_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end
   assign keystream_done_event_o = ks_ev_q;
   assign cipher_done_event_o = cr_ev_q;
   assign error_event_o = er_ev_q;
   assign reg_rdata_o = rdata_q;
   assign mem_req_o = req_q;
   assign mem_we_o = we_q;
   assign mem_addr_o = addr_q;
   assign mem_wdata_o = wdata_q;
endmodule
`default_nettype wire

// ---- tb/ram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ram_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // access port
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic mem_gnt_o,
   output logic [7:0] mem_rdata_o,
   // test control
   input wire logic [15:0] delay_i,
   output var int wr_cnt_o
);
   logic [7:0] mem [0:4095];
   logic [15:0] wait_q;
   logic [7:0] last_q;
   // contention is modelled as a grant held back delay_i cycles
   assign mem_gnt_o = mem_req_i && (wait_q >= delay_i);
   // a released read bus shows the inverse of the last byte read or written
   assign mem_rdata_o = (mem_gnt_o && !mem_we_i) ? mem[mem_addr_i[11:0]] : ~last_q;
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         wait_q <= 16'h0000;
         last_q <= 8'h00;
         wr_cnt_o <= 0;
      end else begin
         wait_q <= (mem_req_i && !mem_gnt_o) ? wait_q + 16'h0001 : 16'h0000;
         if (mem_gnt_o) begin
            last_q <= mem_we_i ? mem_wdata_i : mem_rdata_o;
         end
         if (mem_gnt_o && mem_we_i) begin
            mem[mem_addr_i[11:0]] <= mem_wdata_i;
            wr_cnt_o <= wr_cnt_o + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/ccm_packet_cipher_engine_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccm_consts.svh"
module ccm_cipher_checker (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic keystream_generate_task_i,
   input wire logic cipher_run_task_i,
   input wire logic stop_task_i,
   input wire logic keystream_done_event_o,
   input wire logic cipher_done_event_o,
   input wire logic error_event_o,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic mem_gnt_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [3:0] mode_q;
   logic [7:0] maxpay_q, len_q, cnt_q;
   logic [31:0] scr_q, base_q;
   logic busy_q, ksm_q;
   logic [15:0] stall_q;
   // shadow of mode and scratch registers on write; length and scratch base captured at task start
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         mode_q <= `MODE_RESET;
         maxpay_q <= `MAX_PAY_RESET;
         scr_q <= 32'h0;
         base_q <= 32'h0;
         len_q <= 8'h00;
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         ksm_q <= 1'b0;
         stall_q <= 16'h0000;
      end else if (clk_en_i) begin
         if (reg_wr_i && reg_addr_i == `REG_MODE) mode_q <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == `REG_MAX_PAY) maxpay_q <= reg_wdata_i[7:0];
         if (reg_wr_i && reg_addr_i == `REG_SCRATCH_PTR) scr_q <= reg_wdata_i;
         stall_q <= (mem_req_o && !mem_gnt_i) ? stall_q + 16'h0001 : 16'h0000;
         if (mem_req_o && mem_gnt_i && mem_we_o && ksm_q) cnt_q <= cnt_q + 8'h01;
         if (!busy_q && (keystream_generate_task_i || cipher_run_task_i)) begin
            busy_q <= 1'b1;
            ksm_q <= keystream_generate_task_i;
            cnt_q <= 8'h00;
            base_q <= scr_q;
            len_q <= !mode_q[`MODE_EXTENDED_BIT] ? `KS_DEFAULT_LEN :
               (maxpay_q > `KS_MAX_LEN ? `KS_MAX_LEN : maxpay_q);
         end else if (keystream_done_event_o || cipher_done_event_o || (stop_task_i && !ksm_q)) begin
            busy_q <= 1'b0;
         end
      end
   end
   a_ks_pulse: assert property (keystream_done_event_o |=> !keystream_done_event_o)
      else $error("key-stream done longer than one cycle");
   a_done_pulse: assert property (cipher_done_event_o |=> !cipher_done_event_o)
      else $error("cipher done longer than one cycle");
   a_ks_start: assert property (keystream_generate_task_i && !busy_q && clk_en_i |=> mem_req_o && !mem_we_o)
      else $error("key-stream task did not start a config read");
   a_ks_length: assert property (keystream_done_event_o |-> busy_q && ksm_q && cnt_q == len_q)
      else $error("key-stream length wrong");
   a_ks_region: assert property (busy_q && ksm_q && mem_req_o && mem_we_o |-> (mem_addr_o - base_q) < {24'h0, len_q})
      else $error("key-stream write outside scratch area");
   a_done_busy: assert property (cipher_done_event_o |-> busy_q && !ksm_q)
      else $error("cipher done without a cipher run");
   a_no_req_idle: assert property (!busy_q |-> !mem_req_o)
      else $error("ram request while idle");
   a_req_holds: assert property (mem_req_o && !mem_gnt_i && !stop_task_i |=> mem_req_o
      && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
      else $error("ram request changed before grant");
   a_err_budget: assert property (error_event_o |-> stall_q > 16'(`BYTE_CYC_2M))
      else $error("error event before the wait budget ran out");
endmodule
bind ccm_packet_cipher_engine ccm_cipher_checker ccm_cipher_checker_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .clk_en_i(clk_en_i), .keystream_generate_task_i(keystream_generate_task_i),
   .cipher_run_task_i(cipher_run_task_i), .stop_task_i(stop_task_i),
   .keystream_done_event_o(keystream_done_event_o), .cipher_done_event_o(cipher_done_event_o),
   .error_event_o(error_event_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_gnt_i(mem_gnt_i));
`default_nettype wire

// ---- tb/ccm_packet_cipher_engine_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccm_consts.svh"
module ccm_packet_cipher_engine_bench;
   localparam logic [11:0] CFG = 12'h0c3, SCR = 12'h200, INP = 12'h300, OUTP = 12'h400;
   logic clk_i = 1'b0, rst_b_i = 1'b0, ks_t = 1'b0, run_t = 1'b0, ovr_t = 1'b0;
   logic wr = 1'b0, rd = 1'b0, ks_done, cdone, err, req, we, gnt;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, maddr;
   logic [7:0] mwdata, mrdata, fill = 8'h00;
   logic [15:0] delay = 16'h0000;
   int wcnt, error_cnt = 0, samples_checked = 0, n, err_hits = 0, e0;
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (err === 1'b1) err_hits <= err_hits + 1;
   ccm_packet_cipher_engine ccm_packet_cipher_engine_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(1'b1), .keystream_generate_task_i(ks_t), .cipher_run_task_i(run_t),
      .stop_task_i(1'b0), .rate_override_task_i(ovr_t), .keystream_done_event_o(ks_done),
      .cipher_done_event_o(cdone), .error_event_o(err), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mem_req_o(req), .mem_we_o(we),
      .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_gnt_i(gnt), .mem_rdata_i(mrdata));
   ram_model ram_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .mem_req_i(req), .mem_we_i(we),
      .mem_addr_i(maddr), .mem_wdata_i(mwdata), .mem_gnt_o(gnt), .mem_rdata_o(mrdata),
      .delay_i(delay), .wr_cnt_o(wcnt));
   task summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(rdata & mask, exp, "register read");
   endtask
   task pulse(input int k);
      @(posedge clk_i);
      ks_t <= (k == 0);
      run_t <= (k == 1);
      ovr_t <= (k == 3);
      @(posedge clk_i);
      {ks_t, run_t, ovr_t} <= 3'b000;
   endtask
   task wait_ev(input bit k, input int bound);
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (((k ? cdone : ks_done) !== 1'b1) && n < bound);
      if ((k ? cdone : ks_done) !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH t=%0t wait for done event timed out", $time);
         summarize();
      end
   endtask
   task setup;
      wreg(`REG_CONFIG_PTR, {20'h0, CFG});
      wreg(`REG_SCRATCH_PTR, {20'h0, SCR});
      wreg(`REG_IN_PTR, {20'h0, INP});
      wreg(`REG_OUT_PTR, {20'h0, OUTP});
   endtask
   task automatic ks(input int len);
      int w0, i;
      fill = fill + 8'h3d;
      for (i = 0; i < 256; i++) ram_model_i.mem[CFG + i] = 8'(i * 5) ^ fill;
      w0 = wcnt;
      pulse(0);
      wait_ev(0, 5000);
      chk(wcnt - w0, len, "key-stream bytes");
      for (i = 0; i < len; i++)
         chk(ram_model_i.mem[SCR + i], ram_model_i.mem[CFG + (i % 16)] ^ 8'(i) ^ CFG[7:0],
            "key-stream");
   endtask
   task automatic run(input logic [7:0] len, input logic [3:0] md, input int w, input logic [7:0] ol);
      int w0, i;
      ram_model_i.mem[INP] = 8'h5a;
      ram_model_i.mem[INP + 1] = len;
      for (i = 0; i < len; i++) ram_model_i.mem[INP + 3 + i] = 8'(i) + 8'h11;
      w0 = wcnt;
      wreg(`REG_MODE, {28'h0, md});
      pulse(1);
      wait_ev(1, 20000);
      chk(wcnt - w0, w, "bytes written");
      chk(ram_model_i.mem[OUTP + 1], ol, "length field");
      chk(ram_model_i.mem[OUTP], 8'h5a, "header");
      if (ol != 8'h0)
         chk(ram_model_i.mem[OUTP + 3], ram_model_i.mem[INP + 3] ^ ram_model_i.mem[SCR],
            "payload");
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rreg(`REG_MODE, 32'hffffffff, 32'h1);
      rreg(`REG_MAX_PAY, 32'hffffffff, 32'hfb);
      wreg(4'h9, 32'hffffffff);
      rreg(4'h9, 32'hffffffff, 32'h0);
      setup();
      wreg(`REG_MODE, 32'h0);
      ks(27);
      run(8'd2, 4'h0, 8, 8'd6);
      ks(27);
      run(8'd0, 4'h0, 2, 8'd0);
      wreg(`REG_MODE, 32'h1);
      for (int l = 0; l < 5; l++) begin
         ks(27);
         run(8'(l), 4'h1, 2, 8'd0);
         rreg(`REG_STATUS, 32'h1, (l == 0) ? 32'h1 : 32'h0);
      end
      ks(27);
      run(8'd9, 4'h1, 7, 8'd5);
      wreg(`REG_MAX_PAY, 32'd40);
      wreg(`REG_MODE, 32'h4);
      ks(40);
      wreg(`REG_MAX_PAY, 32'hff);
      ks(251);
      run(8'd40, 4'hc, 46, 8'd44);
      wreg(`REG_RATE_OVR, 32'h0);
      wreg(`REG_MODE, 32'h2);
      ks(27);
      ram_model_i.mem[INP + 1] = 8'd3;
      pulse(1);
      pulse(3);
      rreg(`REG_STATUS, 32'h200, 32'h0);
      e0 = err_hits;
      delay = 16'd600;
      wait_ev(1, 20000);
      delay = 16'd0;
      chk(err_hits - e0, 0, "error after override");
      ks(27);
      e0 = err_hits;
      pulse(1);
      delay = 16'd600;
      for (n = 0; n < 1500 && err_hits == e0; n++) @(posedge clk_i);
      chk(err_hits != e0, 1'b1, "error event");
      if (err_hits == e0) summarize();
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      delay = 16'd0;
      setup();
      ks(27);
      summarize();
   end
endmodule
`default_nettype wire
